// ---- design/i2c_irq_pkg.sv ----
package i2c_irq_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 16;
  localparam logic [31:0] BUS_BUSY_CLR    = 32'h5000135C;
  localparam logic [31:0] STOP_SEEN_CLR   = 32'h50001360;
  localparam logic [31:0] START_SEEN_CLR  = 32'h50001364;
  localparam logic [31:0] BCAST_CLR       = 32'h50001368;
  localparam logic [31:0] ON_CONTROL      = 32'h5000136C;
  localparam logic [31:0] IRQ_STATUS      = 32'h50001390;
  localparam logic [31:0] IRQ_ENABLE      = 32'h50001394;
  localparam logic [31:0] IRQ_CLEAR       = 32'h50001398;
  localparam logic [31:0] CTRL_STATUS     = 32'h5000139C;
  localparam int          BUSY_BIT        = 8;
  localparam int          STOP_BIT        = 9;
  localparam int          START_BIT       = 10;
  localparam int          BCAST_BIT       = 11;
  localparam int          ENABLE_BIT      = 0;
  localparam logic [15:0] ZERO16          = 16'h0000;
  localparam int          ENABLE_DELAY    = 2;
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_TX   = 2'b01,
    XF_RX   = 2'b11,
    XF_STOP = 2'b10
  } xfer_t;
endpackage : i2c_irq_pkg

// ---- design/enable_delay.sv ----
`timescale 1ns/1ps
module enable_delay #(
  parameter int DEPTH = i2c_irq_pkg::ENABLE_DELAY
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] pipe;
  logic [DEPTH-1:0] next_pipe;

  always_comb begin
    next_pipe = {pipe[DEPTH-2:0], din};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pipe <= '0;
    end else begin
      pipe <= next_pipe;
    end
  end

  assign dout = pipe[DEPTH-1];
endmodule : enable_delay

// ---- design/i2c_irq_clear_and_enable.sv ----
`timescale 1ns/1ps
module i2c_irq_clear_and_enable (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] addr,
  input  wire logic [15:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [15:0] rdData,
  input  wire logic        busActive,
  input  wire logic        stopSeen,
  input  wire logic        startSeen,
  input  wire logic        broadcastSeen,
  input  wire logic        txStart,
  input  wire logic        rxStart,
  input  wire logic        byteDone,
  input  wire logic        xferDone,
  output logic             coreEnabled,
  output logic             fifoFlush,
  output logic             txDiscard,
  output logic             rxNack,
  output logic             xferIdle,
  output logic      [15:0] unmasked_irq_flags,
  output logic      [15:0] masked_irq_flags,
  output logic             irq
);
  logic [15:0] irqEnable;
  logic [15:0] next_irqEnable;
  logic        enableReq;
  logic        next_enableReq;
  logic [15:0] next_flags;
  logic [15:0] next_rdData;
  logic        enabledDly;
  logic        enabledQ;
  i2c_irq_pkg::xfer_t xfer;
  i2c_irq_pkg::xfer_t next_xfer;
  logic        next_txDiscard;
  logic        next_rxNack;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  function automatic logic [15:0] bitMask(input int pos);
    bitMask = 16'h0001 << pos;
  endfunction : bitMask

  // the bus-side request only reaches the core after the fixed pipeline
  enable_delay #(
    .DEPTH (i2c_irq_pkg::ENABLE_DELAY)
  ) u_enable_delay (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (enableReq),
    .dout    (enabledDly)
  );

  always_comb begin
    next_enableReq = enableReq;
    next_irqEnable = irqEnable;
    if (wrStb && hit(addr, i2c_irq_pkg::ON_CONTROL)) begin
      next_enableReq = wrData[i2c_irq_pkg::ENABLE_BIT];
    end
    if (wrStb && hit(addr, i2c_irq_pkg::IRQ_ENABLE)) begin
      next_irqEnable = wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enableReq <= 1'b0;
      irqEnable <= i2c_irq_pkg::ZERO16;
      enabledQ  <= 1'b0;
    end else begin
      enableReq <= next_enableReq;
      irqEnable <= next_irqEnable;
      enabledQ  <= enabledDly;
    end
  end

  assign coreEnabled = enabledDly;
  // fifos stay erased for as long as the core is off, not just on the edge
  assign fifoFlush   = ~enabledDly;

  // transfer tracker: disable never cuts a transfer short mid-byte
  always_comb begin
    next_xfer      = xfer;
    next_txDiscard = 1'b0;
    next_rxNack    = 1'b0;
    unique case (xfer)
      i2c_irq_pkg::XF_IDLE: begin
        if (enabledDly && txStart) begin
          next_xfer = i2c_irq_pkg::XF_TX;
        end else if (enabledDly && rxStart) begin
          next_xfer = i2c_irq_pkg::XF_RX;
        end
      end
      i2c_irq_pkg::XF_TX: begin
        if (xferDone) begin
          next_xfer      = enabledDly ? i2c_irq_pkg::XF_IDLE : i2c_irq_pkg::XF_STOP;
          next_txDiscard = ~enabledDly;
        end
      end
      i2c_irq_pkg::XF_RX: begin
        if (!enabledDly && byteDone) begin
          next_xfer   = i2c_irq_pkg::XF_STOP;
          next_rxNack = 1'b1;
        end else if (xferDone) begin
          next_xfer = i2c_irq_pkg::XF_IDLE;
        end
      end
      i2c_irq_pkg::XF_STOP: begin
        next_xfer = i2c_irq_pkg::XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xfer      <= i2c_irq_pkg::XF_IDLE;
      txDiscard <= 1'b0;
      rxNack    <= 1'b0;
    end else begin
      xfer      <= next_xfer;
      txDiscard <= next_txDiscard;
      rxNack    <= next_rxNack;
    end
  end

  assign xferIdle = (xfer == i2c_irq_pkg::XF_IDLE);

  // flags: a new event in the cycle of a clearing read wins
  always_comb begin
    next_flags = unmasked_irq_flags;
    if (rdStb && hit(addr, i2c_irq_pkg::BUS_BUSY_CLR) && !busActive) begin
      next_flags[i2c_irq_pkg::BUSY_BIT] = 1'b0;
    end
    if (!enabledDly && !busActive && xferIdle) begin
      next_flags[i2c_irq_pkg::BUSY_BIT] = 1'b0;
    end
    if (rdStb && hit(addr, i2c_irq_pkg::STOP_SEEN_CLR)) begin
      next_flags[i2c_irq_pkg::STOP_BIT] = 1'b0;
    end
    if (rdStb && hit(addr, i2c_irq_pkg::START_SEEN_CLR)) begin
      next_flags[i2c_irq_pkg::START_BIT] = 1'b0;
    end
    if (rdStb && hit(addr, i2c_irq_pkg::BCAST_CLR)) begin
      next_flags[i2c_irq_pkg::BCAST_BIT] = 1'b0;
    end
    if (wrStb && hit(addr, i2c_irq_pkg::IRQ_CLEAR)) begin
      next_flags = next_flags & ~(wrData & ~bitMask(i2c_irq_pkg::BUSY_BIT));
    end
    if (busActive) begin
      next_flags[i2c_irq_pkg::BUSY_BIT] = 1'b1;
    end
    if (stopSeen) begin
      next_flags[i2c_irq_pkg::STOP_BIT] = 1'b1;
    end
    if (startSeen) begin
      next_flags[i2c_irq_pkg::START_BIT] = 1'b1;
    end
    if (broadcastSeen) begin
      next_flags[i2c_irq_pkg::BCAST_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unmasked_irq_flags <= i2c_irq_pkg::ZERO16;
    end else begin
      unmasked_irq_flags <= next_flags;
    end
  end

  // masking is not gated by enable, so status lives on while the core is off; only busy self-clears once bus and transfer are idle
  assign masked_irq_flags = unmasked_irq_flags & irqEnable;
  assign irq              = |masked_irq_flags;

  always_comb begin
    next_rdData = i2c_irq_pkg::ZERO16;
    if (rdStb) begin
      if (hit(addr, i2c_irq_pkg::BUS_BUSY_CLR)) begin
        next_rdData[0] = unmasked_irq_flags[i2c_irq_pkg::BUSY_BIT];
      end else if (hit(addr, i2c_irq_pkg::STOP_SEEN_CLR)) begin
        next_rdData[0] = unmasked_irq_flags[i2c_irq_pkg::STOP_BIT];
      end else if (hit(addr, i2c_irq_pkg::START_SEEN_CLR)) begin
        next_rdData[0] = unmasked_irq_flags[i2c_irq_pkg::START_BIT];
      end else if (hit(addr, i2c_irq_pkg::BCAST_CLR)) begin
        next_rdData[0] = unmasked_irq_flags[i2c_irq_pkg::BCAST_BIT];
      end else if (hit(addr, i2c_irq_pkg::ON_CONTROL)) begin
        next_rdData[0] = enableReq;
      end else if (hit(addr, i2c_irq_pkg::IRQ_STATUS)) begin
        next_rdData = unmasked_irq_flags;
      end else if (hit(addr, i2c_irq_pkg::IRQ_ENABLE)) begin
        next_rdData = irqEnable;
      end else if (hit(addr, i2c_irq_pkg::CTRL_STATUS)) begin
        next_rdData = {13'h0000, xferIdle, enabledQ, enabledDly};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData <= i2c_irq_pkg::ZERO16;
    end else begin
      rdData <= next_rdData;
    end
  end
endmodule : i2c_irq_clear_and_enable

// ---- bench/i2c_irq_checker.sv ----
`timescale 1ns/1ps
module i2c_irq_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [31:0] addr,
  input wire logic [15:0] wrData,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [15:0] rdData,
  input wire logic        busActive,
  input wire logic        coreEnabled,
  input wire logic        fifoFlush,
  input wire logic        xferIdle,
  input wire logic [15:0] unmasked_irq_flags
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_busyClr; rdStb && addr == i2c_irq_pkg::BUS_BUSY_CLR && !busActive |=> !unmasked_irq_flags[8]; endproperty
  a_busyClr: assert property (p_busyClr) else $error("busy flag kept");
  property p_busyKeep; rdStb && addr == i2c_irq_pkg::BUS_BUSY_CLR && busActive |=> unmasked_irq_flags[8]; endproperty
  a_busyKeep: assert property (p_busyKeep) else $error("busy flag lost");
  property p_autoClr; (!coreEnabled && !busActive && xferIdle) [*2] |-> !unmasked_irq_flags[8]; endproperty
  a_autoClr: assert property (p_autoClr) else $error("busy flag not self cleared");
  property p_busyRd; rdStb && addr == i2c_irq_pkg::BUS_BUSY_CLR |=> rdData == {15'h0000, $past(unmasked_irq_flags[8])}; endproperty
  a_busyRd: assert property (p_busyRd) else $error("busy read value");
  property p_startClr; rdStb && addr == i2c_irq_pkg::START_SEEN_CLR |=> !unmasked_irq_flags[10]; endproperty
  a_startClr: assert property (p_startClr) else $error("start flag kept");
  property p_bcastClr; rdStb && addr == i2c_irq_pkg::BCAST_CLR |=> !unmasked_irq_flags[11]; endproperty
  a_bcastClr: assert property (p_bcastClr) else $error("broadcast flag kept");
  property p_flush; fifoFlush == !coreEnabled; endproperty
  a_flush: assert property (p_flush) else $error("flush not tied to enable");
  // the strobe edge registers the request, then two more edges pass
  property p_enDelay; wrStb && addr == i2c_irq_pkg::ON_CONTROL |-> ##3 coreEnabled == $past(wrData[0], 3); endproperty
  a_enDelay: assert property (p_enDelay) else $error("enable delay wrong");
endmodule : i2c_irq_checker
bind i2c_irq_clear_and_enable i2c_irq_checker i_chk (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData),
  .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .busActive(busActive), .coreEnabled(coreEnabled),
  .fifoFlush(fifoFlush), .xferIdle(xferIdle), .unmasked_irq_flags(unmasked_irq_flags));

// ---- bench/i2c_bus_model.sv ----
`timescale 1ns/1ps
// events: 0 stop, 1 start, 2 broadcast, 3 tx start, 4 rx start, 5 byte end, 6 transfer end
module i2c_bus_model (
  input  wire logic       ref_clk,
  output logic            busActive,
  output logic      [6:0] ev
);
  initial begin
    busActive = 1'b0;
    ev = 7'h00;
  end
  task pulse(input int i);
    @(posedge ref_clk);
    ev <= 7'h01 << i;
    @(posedge ref_clk);
    ev <= 7'h00;
  endtask : pulse
  task hold(input logic a);
    @(posedge ref_clk);
    busActive <= a;
  endtask : hold
endmodule : i2c_bus_model

// ---- bench/i2c_irq_clear_and_enable_test.sv ----
`timescale 1ns/1ps
module i2c_irq_clear_and_enable_test;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [31:0] addr;
  logic [15:0] wrData;
  logic        wrStb   = 1'b0;
  logic        rdStb   = 1'b0;
  logic [15:0] rdData, flags, maskedFlags;
  logic [31:0] regs [5] = '{32'h5000135C, 32'h50001360, 32'h50001364, 32'h50001368, 32'h5000136C};
  logic [31:0] clears [3] = '{32'h50001360, 32'h50001364, 32'h50001368};
  logic        busActive, coreEnabled, fifoFlush, txDiscard, rxNack, xferIdle, irq, seen;
  logic [6:0]  ev;
  int          errCount = 0;
  int          compares = 0;
  int          cycles   = 0;
  always #50 ref_clk = ~ref_clk;
  i2c_bus_model i_i2c_bus_model (.ref_clk(ref_clk), .busActive(busActive), .ev(ev));
  i2c_irq_clear_and_enable i_i2c_irq_clear_and_enable (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .busActive(busActive), .stopSeen(ev[0]),
    .startSeen(ev[1]), .broadcastSeen(ev[2]), .txStart(ev[3]), .rxStart(ev[4]), .byteDone(ev[5]),
    .xferDone(ev[6]), .coreEnabled(coreEnabled), .fifoFlush(fifoFlush), .txDiscard(txDiscard),
    .rxNack(rxNack), .xferIdle(xferIdle), .unmasked_irq_flags(flags), .masked_irq_flags(maskedFlags), .irq(irq));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 chk(rdData, e);
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // done pulses rise on the same edge that ends the model's pulse and stand for one cycle
  task finishAndSee(input int i);
    i_i2c_bus_model.pulse(i);
    #1 seen = (i == 6 ? txDiscard : rxNack);
    repeat (2) begin
      @(posedge ref_clk);
      #1 seen = seen | (i == 6 ? txDiscard : rxNack);
    end
  endtask : finishAndSee
  task t_resetValues;
    foreach (regs[i]) rd(regs[i], 16'h0000);
    rd(32'h50001400, 16'h0000);
    chk(fifoFlush, 1'b1);
  endtask : t_resetValues
  task t_enable;
    wr(i2c_irq_pkg::ON_CONTROL, 16'hFFFF);
    tick(1);
    chk(coreEnabled, 1'b0);
    tick(1);
    chk(coreEnabled, 1'b1);
    chk(fifoFlush, 1'b0);
    rd(i2c_irq_pkg::ON_CONTROL, 16'h0001);
  endtask : t_enable
  task t_busy;
    i_i2c_bus_model.hold(1'b1);
    wr(i2c_irq_pkg::IRQ_ENABLE, 16'h0100);
    tick(1);
    chk(irq, 1'b1);
    chk(maskedFlags, 16'h0100);
    rd(i2c_irq_pkg::BUS_BUSY_CLR, 16'h0001);
    chk(flags[8], 1'b1);
    i_i2c_bus_model.hold(1'b0);
    rd(i2c_irq_pkg::BUS_BUSY_CLR, 16'h0001);
    chk(flags[8], 1'b0);
    chk(irq, 1'b0);
  endtask : t_busy
  task t_events;
    for (int i = 0; i < 3; i++) begin
      i_i2c_bus_model.pulse(i);
      tick(1);
      chk(flags[9 + i], 1'b1);
      chk(irq, 1'b0);
      rd(clears[i], 16'h0001);
      chk(flags[9 + i], 1'b0);
    end
    i_i2c_bus_model.pulse(2);
    wr(i2c_irq_pkg::IRQ_CLEAR, 16'h0800);
    tick(1);
    chk(flags[11], 1'b0);
  endtask : t_events
  task t_disable;
    i_i2c_bus_model.pulse(3);
    tick(1);
    chk(xferIdle, 1'b0);
    wr(i2c_irq_pkg::ON_CONTROL, 16'h0000);
    tick(3);
    chk(fifoFlush, 1'b1);
    chk(txDiscard, 1'b0);
    finishAndSee(6);
    chk(seen, 1'b1);
    chk(xferIdle, 1'b1);
    wr(i2c_irq_pkg::ON_CONTROL, 16'h0001);
    tick(3);
    i_i2c_bus_model.pulse(4);
    wr(i2c_irq_pkg::ON_CONTROL, 16'h0000);
    tick(3);
    finishAndSee(5);
    chk(seen, 1'b1);
    i_i2c_bus_model.hold(1'b1);
    tick(2);
    chk(flags[8], 1'b1);
    i_i2c_bus_model.hold(1'b0);
    tick(3);
    chk(flags[8], 1'b0);
  endtask : t_disable
  task summarize;
    $display("errors=%0d compares=%0d", errCount, compares);
    if (errCount == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errCount++;
      summarize();
    end
  end
  initial begin
    addr <= 32'h00000000;
    wrData <= 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_resetValues();
    t_enable();
    t_busy();
    t_events();
    t_disable();
    summarize();
  end
endmodule : i2c_irq_clear_and_enable_test
